/* File: bus_handshake_defines.vh */
// Purpose: Register map, field positions and command codes of the
//          instrument bus handshake and status block.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes:   Definitions only.
`ifndef BUS_HANDSHAKE_DEFINES_VH
`define BUS_HANDSHAKE_DEFINES_VH

// Register byte offsets
`define OFS_INT_STATUS   8'h00
`define OFS_ADDR_STATUS  8'h04
`define OFS_MODE_CTRL    8'h08
`define OFS_AUX_CMD      8'h0C
`define OFS_MY_ADDR      8'h10
`define OFS_INT_MASK     8'h14
`define OFS_SPOLL        8'h18
`define OFS_DATA         8'h1C

// Mode control fields
`define MODE_DSEL        7
`define MODE_HOLD_ALL    6
`define MODE_EXT_ADDR    5
// Aux command fields
`define AUX_HOLD_REL     1
// Interrupt status fields
`define IST_BYTE_IN      0
`define IST_TRIG         5
// Address status fields
`define AST_LPAS         0
`define AST_TPAS         1
`define AST_LACS         2
`define AST_TACS         3
`define AST_SPAS         4

// Reset values
`define MODE_RESET       8'h00
`define MASK_RESET       8'h00
`define ADDR_RESET       5'h00

// Bus command codes (seven bits, parity ignored)
`define CMD_GET          7'h08
`define CMD_SPE          7'h18
`define CMD_SPD          7'h19
`define CMD_UNL          7'h3F
`define CMD_UNT          7'h5F

`endif

/* File: acceptor_handshake.v */
// Purpose: Acceptor handshake of the listener, with byte capture.
// Assumes: Bus lines are synchronous to pclk; levels are true-high.
// Notes:   rfd_r and dac_r high mean the line is released (true).
`timescale 1ns/1ns
`default_nettype none

module acceptor_handshake (
    // Clock and reset
    input  wire       pclk,
    input  wire       presetn,
    input  wire       ce,
    // Control
    input  wire       active,
    input  wire       hold_all,
    input  wire       read_done,
    input  wire       hold_release,
    // Bus side
    input  wire       dav_in,
    input  wire       atn_in,
    input  wire [7:0] dio_in,
    output reg        rfd_r,
    output reg        dac_r,
    // Captured byte
    output reg  [7:0] byte_r,
    output reg        cmd_r,
    output reg        got_r
);

localparam A_IDLE = 2'd0;
localparam A_ACPT = 2'd1;
localparam A_DONE = 2'd2;
localparam A_HOLD = 2'd3;

reg [1:0] state_r;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_r <= A_IDLE;
        rfd_r   <= 1'b1;
        dac_r   <= 1'b1;
        byte_r  <= 8'h00;
        cmd_r   <= 1'b0;
        got_r   <= 1'b0;
    end else if (ce) begin
        got_r <= 1'b0;
        case (state_r)
            A_IDLE: begin
                rfd_r <= 1'b1;
                dac_r <= ~active;
                if (active && dav_in) begin
                    byte_r  <= dio_in;
                    cmd_r   <= atn_in;
                    got_r   <= 1'b1;
                    rfd_r   <= 1'b0;
                    dac_r   <= 1'b0;
                    state_r <= A_ACPT;
                end
            end
            A_ACPT: begin
                // Data keeps DAC low until the processor has read it
                if (cmd_r || read_done) begin
                    dac_r   <= 1'b1;
                    state_r <= A_DONE;
                end
            end
            A_DONE: begin
                if (!dav_in) begin
                    dac_r <= 1'b0;
                    // Commands never hold off
                    if (hold_all && !cmd_r) begin
                        state_r <= A_HOLD;
                    end else begin
                        rfd_r   <= 1'b1;
                        state_r <= A_IDLE;
                    end
                end
            end
            default: begin
                if (hold_release) begin
                    rfd_r   <= 1'b1;
                    state_r <= A_IDLE;
                end
            end
        endcase
    end
end

endmodule
`default_nettype wire

/* File: bus_handshake_status.v */
// Purpose: Listener/talker handshake and status of an instrument bus
//          adapter, with an APB register file.
// Assumes: Bus lines synchronous to pclk, true-high; pclk 50 MHz.
// Notes:   APB answers with zero wait states.
// Notes on behaviour
// - A received data byte keeps DAC held until software reads it.
// - DAC is released only after the read access has ended.
// - With trigger deselect set, a trigger command sets no status.
// - With hold-all-data set, RFD is held after every data byte.
// - The hold applies to data bytes only, never to commands.
// - A pending transmit byte survives a serial poll takeover.
// - Back in talker active state the pending byte is sent normally.
// - The primary-addressed bits show only LPAS and TPAS.
// - Address status bits 2 and 3 show listener and talker active.
// - With extended addressing, a foreign primary address after our own primary address idles us.
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "bus_handshake_defines.vh"

module bus_handshake_status (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Instrument bus
    input  wire [7:0]  dio_in,
    input  wire        dav_in,
    input  wire        rfd_in,
    input  wire        dac_in,
    input  wire        atn_in,
    output reg  [7:0]  dio_out,
    output reg         dio_oe,
    output reg         dav_out,
    output wire        rfd_out,
    output wire        dac_out,
    // Interrupt request
    output reg         irq
);

localparam S_IDLE = 2'd0;
localparam S_DAV  = 2'd1;
localparam S_WAIT = 2'd2;

reg  [7:0] mode_control_register_r;
reg  [7:0] int_mask_r;
reg  [4:0] my_addr_r;
reg  [7:0] spoll_r;
reg  [7:0] transmit_byte_register_r;
reg  [7:0] received_byte_register_r;
reg        byte_in_r;
reg        trig_r;
reg        nba_r;
reg        lpas_r;
reg        tpas_r;
reg        lads_r;
reg        tads_r;
reg        spms_r;
reg        lacs_r;
reg        tacs_r;
reg        spas_r;
reg        sp_sent_r;
reg        rd_done_r;
reg        hold_rel_r;
reg  [1:0] sh_state_r;

wire       acc_got;
wire       acc_cmd;
wire [7:0] acc_byte;
wire       wr_acc   = psel & penable & pwrite;
wire       rd_acc   = psel & penable & ~pwrite;
wire       cmd_ev   = acc_got & acc_cmd;
wire       data_ev  = acc_got & ~acc_cmd;
wire [6:0] cmd7     = acc_byte[6:0];
wire       is_lag   = cmd7[6:5] == 2'b01;
wire       is_tag   = cmd7[6:5] == 2'b10;
wire       is_sec   = cmd7[6:5] == 2'b11;
wire       is_mla   = is_lag & (cmd7[4:0] == my_addr_r) & (cmd7 != `CMD_UNL);
wire       is_mta   = is_tag & (cmd7[4:0] == my_addr_r) & (cmd7 != `CMD_UNT);
wire       ext_mode = mode_control_register_r[`MODE_EXT_ADDR];
wire       dsel     = mode_control_register_r[`MODE_DSEL];
wire       rd_data  = rd_acc & (paddr == `OFS_DATA);
wire       rd_ist   = rd_acc & (paddr == `OFS_INT_STATUS);
wire       wr_tx    = wr_acc & (paddr == `OFS_DATA);
wire       sh_done  = (sh_state_r == S_WAIT) & dac_in;
wire       talk_on  = (tacs_r & nba_r) | (spas_r & ~sp_sent_r);
wire [7:0] ist_val  = {2'b00, trig_r, 4'h0, byte_in_r};
wire [7:0] ast_val  = {3'b000, spas_r, tacs_r, lacs_r, tpas_r, lpas_r};

////////////////////////////////////////////////////////////////////////
// Acceptor handshake

acceptor_handshake u_acceptor (
    .pclk         (pclk),
    .presetn      (presetn),
    .ce           (ce),
    .active       (lacs_r | atn_in),
    .hold_all     (mode_control_register_r[`MODE_HOLD_ALL]),
    .read_done    (rd_done_r),
    .hold_release (hold_rel_r),
    .dav_in       (dav_in),
    .atn_in       (atn_in),
    .dio_in       (dio_in),
    .rfd_r        (rfd_out),
    .dac_r        (dac_out),
    .byte_r       (acc_byte),
    .cmd_r        (acc_cmd),
    .got_r        (acc_got)
);

////////////////////////////////////////////////////////////////////////
// APB registers and read path

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        mode_control_register_r  <= `MODE_RESET;
        int_mask_r               <= `MASK_RESET;
        my_addr_r                <= `ADDR_RESET;
        spoll_r                  <= 8'h00;
        transmit_byte_register_r <= 8'h00;
        prdata                   <= 32'h0000_0000;
        pready                   <= 1'b0;
        pslverr                  <= 1'b0;
        rd_done_r                <= 1'b0;
        hold_rel_r               <= 1'b0;
    end else if (ce) begin
        pready <= psel & ~penable;
        // Release pulse lands on the edge that ends the access
        rd_done_r  <= rd_data & pready;
        hold_rel_r <= 1'b0;
        if (psel && !penable) begin
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (paddr == `OFS_INT_STATUS) begin
                prdata[7:0] <= ist_val;
            end else if (paddr == `OFS_ADDR_STATUS) begin
                prdata[7:0] <= ast_val;
            end else if (paddr == `OFS_MODE_CTRL) begin
                prdata[7:0] <= mode_control_register_r;
            end else if (paddr == `OFS_AUX_CMD) begin
                prdata[7:0] <= 8'h00;
            end else if (paddr == `OFS_MY_ADDR) begin
                prdata[4:0] <= my_addr_r;
            end else if (paddr == `OFS_INT_MASK) begin
                prdata[7:0] <= int_mask_r;
            end else if (paddr == `OFS_SPOLL) begin
                prdata[7:0] <= spoll_r;
            end else if (paddr == `OFS_DATA) begin
                prdata[7:0] <= received_byte_register_r;
            end else begin
                pslverr <= 1'b1;
            end
        end
        if (wr_acc && pready) begin
            if (paddr == `OFS_MODE_CTRL) begin
                mode_control_register_r <= pwdata[7:0];
            end else if (paddr == `OFS_AUX_CMD) begin
                hold_rel_r <= pwdata[`AUX_HOLD_REL];
            end else if (paddr == `OFS_MY_ADDR) begin
                my_addr_r <= pwdata[4:0];
            end else if (paddr == `OFS_INT_MASK) begin
                int_mask_r <= pwdata[7:0];
            end else if (paddr == `OFS_SPOLL) begin
                spoll_r <= pwdata[7:0];
            end else if (paddr == `OFS_DATA) begin
                transmit_byte_register_r <= pwdata[7:0];
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Addressing, status flags and interrupt

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        lpas_r    <= 1'b0;
        tpas_r    <= 1'b0;
        lads_r    <= 1'b0;
        tads_r    <= 1'b0;
        spms_r    <= 1'b0;
        lacs_r    <= 1'b0;
        tacs_r    <= 1'b0;
        spas_r    <= 1'b0;
        trig_r    <= 1'b0;
        byte_in_r <= 1'b0;
        received_byte_register_r <= 8'h00;
        irq       <= 1'b0;
    end else if (ce) begin
        if (cmd_ev && (is_lag || is_tag)) begin
            lpas_r <= ext_mode & is_mla;
            tpas_r <= ext_mode & is_mta;
            if (ext_mode && (lpas_r || tpas_r) && !is_mla && !is_mta) begin
                lads_r <= 1'b0;
                tads_r <= 1'b0;
            end else if (is_lag) begin
                if (cmd7 == `CMD_UNL) begin
                    lads_r <= 1'b0;
                end else if (is_mla && !ext_mode) begin
                    lads_r <= 1'b1;
                end
            end else begin
                if (is_mta && !ext_mode) begin
                    tads_r <= 1'b1;
                end else if (!is_mta) begin
                    tads_r <= 1'b0;
                end
            end
        end else if (cmd_ev && is_sec && ext_mode) begin
            if (lpas_r) begin
                lads_r <= 1'b1;
            end
            if (tpas_r) begin
                tads_r <= 1'b1;
            end
            lpas_r <= 1'b0;
            tpas_r <= 1'b0;
        end
        if (cmd_ev && cmd7 == `CMD_SPE) begin
            spms_r <= 1'b1;
        end else if (cmd_ev && cmd7 == `CMD_SPD) begin
            spms_r <= 1'b0;
        end
        lacs_r <= lads_r & ~atn_in;
        tacs_r <= tads_r & ~atn_in & ~spms_r;
        spas_r <= tads_r & ~atn_in & spms_r;
        // Hardware set wins over the clear by reading
        if (cmd_ev && lads_r && cmd7 == `CMD_GET && !dsel) begin
            trig_r <= 1'b1;
        end else if (rd_ist && pready) begin
            trig_r <= 1'b0;
        end
        if (data_ev) begin
            received_byte_register_r <= acc_byte;
            byte_in_r                <= 1'b1;
        end else if (rd_done_r) begin
            byte_in_r <= 1'b0;
        end
        // Deselected trigger cannot reach irq since trig_r stays clear
        irq <= |(ist_val & int_mask_r);
    end
end

////////////////////////////////////////////////////////////////////////
// Source handshake

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sh_state_r <= S_IDLE;
        dav_out    <= 1'b0;
        dio_out    <= 8'h00;
        dio_oe     <= 1'b0;
        nba_r      <= 1'b0;
        sp_sent_r  <= 1'b0;
    end else if (ce) begin
        dio_oe <= tacs_r | spas_r;
        if (!spas_r) begin
            sp_sent_r <= 1'b0;
        end
        // New write wins over completion of the previous byte
        if (wr_tx && pready) begin
            nba_r <= 1'b1;
        end else if (sh_done && tacs_r) begin
            nba_r <= 1'b0;
        end
        case (sh_state_r)
            S_IDLE: begin
                dav_out <= 1'b0;
                dio_out <= spas_r ? spoll_r : transmit_byte_register_r;
                if (talk_on && rfd_in) begin
                    dav_out    <= 1'b1;
                    sh_state_r <= S_DAV;
                end
            end
            S_DAV: begin
                sh_state_r <= S_WAIT;
            end
            default: begin
                if (!(tacs_r || spas_r)) begin
                    // Takeover aborts the cycle, nba is left pending
                    dav_out    <= 1'b0;
                    sh_state_r <= S_IDLE;
                end else if (dac_in) begin
                    dav_out    <= 1'b0;
                    sp_sent_r  <= spas_r;
                    sh_state_r <= S_IDLE;
                end
            end
        endcase
    end
end

endmodule
`default_nettype wire

/* File: bus_handshake_status_chk.sv */
// Purpose: Port checker for bus_handshake_status.
// Assumes: One clock, zero-wait APB, ce low only while no APB access runs.
// Notes:   Mode bits are tracked from APB writes.
`timescale 1ns/1ns
`default_nettype none
`include "bus_handshake_defines.vh"

module bus_handshake_status_chk (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Instrument bus
    input wire logic [7:0]  dio_in,
    input wire logic        dav_in,
    input wire logic        rfd_in,
    input wire logic        dac_in,
    input wire logic        atn_in,
    input wire logic [7:0]  dio_out,
    input wire logic        dio_oe,
    input wire logic        dav_out,
    input wire logic        rfd_out,
    input wire logic        dac_out,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    wire acc = psel && penable && pready;
    wire rd_dat = acc && !pwrite && paddr == `OFS_DATA;
    wire rd_ast = acc && !pwrite && paddr == `OFS_ADDR_STATUS;
    wire rel_wr = acc && pwrite && paddr == `OFS_AUX_CMD
                  && pwdata[`AUX_HOLD_REL];
    logic [7:0] mode_r;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            mode_r <= `MODE_RESET;
        else if (acc && pwrite && paddr == `OFS_MODE_CTRL && !pslverr)
            mode_r <= pwdata[7:0];
    end
    ////////////////////////////////////////
    a_dac_held: assert property (
        !dac_out && dav_in && !atn_in && !rd_dat && !$past(rd_dat)
        && !$past(rd_dat, 2) |=> !dac_out) else $error("dac left early");
    a_dac_after_read: assert property (
        $rose(dac_out) && dav_in && !atn_in
        |-> $past(rd_dat, 2) || $past(rd_dat, 3))
        else $error("dac without read");
    a_trig_quiet: assert property (
        mode_r[`MODE_DSEL] && atn_in && $rose(dav_in)
        && dio_in[6:0] == `CMD_GET |-> ##1 (!$rose(irq)) [*4])
        else $error("irq on deselected trigger");
    a_hold_rfd: assert property (
        mode_r[`MODE_HOLD_ALL] && !rfd_out && !dav_in && !atn_in
        && !rel_wr && !$past(rel_wr) && !$past(rel_wr, 2) |=> !rfd_out)
        else $error("rfd hold lost");
    a_hold_release: assert property (
        rel_wr && !rfd_out && !dav_in && !atn_in |-> ##[1:3] rfd_out)
        else $error("rfd not released");
    a_cmd_no_hold: assert property (
        atn_in && $past(atn_in) && $fell(dav_in) |-> ##[1:2] rfd_out)
        else $error("rfd held on command");
    a_dav_stands: assert property (
        dav_out && !dac_in && !atn_in |=> dav_out && $stable(dio_out))
        else $error("source byte dropped");
    a_dav_start: assert property (
        $rose(dav_out) |-> $past(rfd_in) && dio_oe)
        else $error("dav without ready");
    a_prim_bits: assert property (
        rd_ast && !mode_r[`MODE_EXT_ADDR] |-> prdata[1:0] == 2'h0)
        else $error("primary bits set");
    a_active_bits: assert property (
        rd_ast && prdata[3:2] != 2'h0 |-> !$past(atn_in, 2))
        else $error("active bit under atn");
endmodule

bind bus_handshake_status bus_handshake_status_chk i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dio_in(dio_in),
    .dav_in(dav_in), .rfd_in(rfd_in), .dac_in(dac_in), .atn_in(atn_in),
    .dio_out(dio_out), .dio_oe(dio_oe), .dav_out(dav_out),
    .rfd_out(rfd_out), .dac_out(dac_out), .irq(irq));
`default_nettype wire

/* File: bus_far_end.sv */
// Purpose: Controller, talker and listener on the far bus side.
// Assumes: Lines true-high, synchronous to pclk.
// Notes:   Released data lines show the inverse of the last value.
`timescale 1ns/1ns
`default_nettype none

module bus_far_end (
    // Clock
    input  wire logic       pclk,
    // Toward the block
    output logic      [7:0] dio_in,
    output logic            dav_in,
    output logic            rfd_in,
    output logic            dac_in,
    output logic            atn_in,
    // From the block
    input  wire logic [7:0] dio_out,
    input  wire logic       dav_out,
    input  wire logic       rfd_out,
    input  wire logic       dac_out
);
    logic       lsn_on;
    logic [7:0] heard;
    int         n_heard;
    int         stalls;
    initial begin
        {dio_in, dav_in, rfd_in, dac_in, atn_in, lsn_on} = 13'h0;
        heard = 8'h0;
        n_heard = 0;
        stalls = 0;
    end
    ////////////////////////////////////////
    task automatic set_atn(input logic v);
        @(posedge pclk);
        atn_in <= v;
    endtask
    task automatic put(input logic [7:0] b);
        int n;
        @(posedge pclk);
        for (n = 0; n < 300 && rfd_out !== 1'b1; n++)
            @(posedge pclk);
        if (rfd_out !== 1'b1)
            stalls++;
        dio_in <= b;
        dav_in <= 1'b1;
    endtask
    task automatic done;
        int n;
        // Let the block see DAV first; a passive DAC is high already
        @(posedge pclk);
        for (n = 0; n < 300 && dac_out !== 1'b1; n++)
            @(posedge pclk);
        if (dac_out !== 1'b1)
            stalls++;
        dav_in <= 1'b0;
        @(posedge pclk);
        dio_in <= ~dio_in;
    endtask
    task automatic cmd(input logic [7:0] b);
        put(b);
        done;
    endtask
    // Listener is slow on purpose: one idle edge between handshakes
    always @(posedge pclk) begin
        if (lsn_on && dav_out && !dac_in) begin
            heard <= dio_out;
            n_heard <= n_heard + 1;
            dac_in <= 1'b1;
            rfd_in <= 1'b0;
        end else if (!dav_out) begin
            dac_in <= 1'b0;
            rfd_in <= lsn_on;
        end
    end
endmodule
`default_nettype wire

/* File: bus_handshake_status_test.sv */
// Purpose: Self-checking bench for bus_handshake_status.
// Assumes: Zero-wait APB, my address left at reset value 0.
// Notes:   ce is dropped once, while a command byte stands on the bus.
`timescale 1ns/1ns
`default_nettype none
`include "bus_handshake_defines.vh"

module bus_handshake_status_test;
    logic        pclk, presetn, psel, penable, pwrite, e, ce;
    logic [7:0]  paddr, dio_in;
    logic [31:0] pwdata, q;
    wire  [31:0] prdata;
    wire  [7:0]  dio_out;
    wire         pready, pslverr, dio_oe, dav_out, rfd_out, dac_out, irq;
    logic        dav_in, rfd_in, dac_in, atn_in;
    int          bad_count = 0;
    int          check_count = 0;
    bus_handshake_status i_dut (.pclk(pclk), .presetn(presetn),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dio_in(dio_in), .dav_in(dav_in),
        .rfd_in(rfd_in), .dac_in(dac_in), .atn_in(atn_in),
        .dio_out(dio_out), .dio_oe(dio_oe), .dav_out(dav_out),
        .rfd_out(rfd_out), .dac_out(dac_out), .irq(irq));
    bus_far_end i_far (.pclk(pclk), .dio_in(dio_in), .dav_in(dav_in),
        .rfd_in(rfd_in), .dac_in(dac_in), .atn_in(atn_in),
        .dio_out(dio_out), .dav_out(dav_out), .rfd_out(rfd_out),
        .dac_out(dac_out));
    ////////////////////////////////////////
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            end_sim;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, q, x);
    endtask
    task wait_heard(input int k);
        int n;
        for (n = 0; n < 300 && i_far.n_heard < k; n++)
            @(posedge pclk);
        if (i_far.n_heard < k) begin
            bad_count++;
            end_sim;
        end
    endtask
    ////////////////////////////////////////
    task t_reset;
        chk("rfd_out", rfd_out, 32'h1);
        chk("dac_out", dac_out, 32'h1);
        chk("irq", irq, 32'h0);
        rd("mode", `OFS_MODE_CTRL, 32'h0);
        apb(1'b0, 8'h3C, 32'h0);
        chk("slverr", e, 32'h1);
    endtask
    task t_listen;
        i_far.set_atn(1'b1);
        i_far.cmd(8'h20);
        i_far.set_atn(1'b0);
        rd("addr status", `OFS_ADDR_STATUS, 32'h4);
        i_far.put(8'h5A);
        repeat (6) @(posedge pclk);
        chk("dac_out", dac_out, 32'h0);
        rd("byte", `OFS_DATA, 32'h5A);
        @(posedge pclk);
        chk("dac_out", dac_out, 32'h0);
        i_far.done;
    endtask
    task t_hold;
        wr(`OFS_MODE_CTRL, 32'h40);
        i_far.put(8'h11);
        // The byte needs two edges to reach the received register
        repeat (3) @(posedge pclk);
        rd("byte", `OFS_DATA, 32'h11);
        i_far.done;
        repeat (4) @(posedge pclk);
        chk("rfd_out", rfd_out, 32'h0);
        wr(`OFS_AUX_CMD, 32'h2);
        repeat (3) @(posedge pclk);
        chk("rfd_out", rfd_out, 32'h1);
        i_far.set_atn(1'b1);
        i_far.cmd(8'h20);
        repeat (3) @(posedge pclk);
        chk("rfd_out", rfd_out, 32'h1);
        wr(`OFS_MODE_CTRL, 32'h0);
    endtask
    task t_trig;
        wr(`OFS_INT_MASK, 32'h20);
        wr(`OFS_MODE_CTRL, 32'h80);
        ce <= 1'b0;
        i_far.put({1'b0, `CMD_GET});
        repeat (4) @(posedge pclk);
        chk("frozen rfd_out", rfd_out, 32'h1);
        ce <= 1'b1;
        i_far.done;
        repeat (3) @(posedge pclk);
        chk("irq", irq, 32'h0);
        rd("int status", `OFS_INT_STATUS, 32'h0);
        wr(`OFS_MODE_CTRL, 32'h0);
        i_far.cmd({1'b0, `CMD_GET});
        repeat (3) @(posedge pclk);
        chk("irq", irq, 32'h1);
        rd("int status", `OFS_INT_STATUS, 32'h20);
    endtask
    // Pending byte must survive a poll taken while the listener stalls
    task t_talk;
        i_far.cmd({1'b0, `CMD_UNL});
        i_far.cmd(8'h40);
        wr(`OFS_SPOLL, 32'h41);
        i_far.set_atn(1'b0);
        wr(`OFS_DATA, 32'hC3);
        i_far.set_atn(1'b1);
        i_far.cmd({1'b0, `CMD_SPE});
        i_far.set_atn(1'b0);
        @(posedge pclk);
        i_far.lsn_on <= 1'b1;
        wait_heard(1);
        chk("poll byte", i_far.heard, 32'h41);
        chk("dio_oe", dio_oe, 32'h1);
        i_far.set_atn(1'b1);
        i_far.cmd({1'b0, `CMD_SPD});
        i_far.set_atn(1'b0);
        wait_heard(2);
        chk("pending byte", i_far.heard, 32'hC3);
    endtask
    task t_ext;
        i_far.set_atn(1'b1);
        wr(`OFS_MODE_CTRL, 32'h20);
        i_far.cmd(8'h20);
        rd("addr status", `OFS_ADDR_STATUS, 32'h1);
        i_far.cmd(8'h21);
        // Without the return to idle the old talk address would go active
        i_far.set_atn(1'b0);
        rd("addr status", `OFS_ADDR_STATUS, 32'h0);
        chk("dio_oe", dio_oe, 32'h0);
    endtask
    ////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        repeat (100000) @(posedge pclk);
        bad_count++;
        end_sim;
    end
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        ce = 1'b1;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_listen;
        t_hold;
        t_trig;
        t_talk;
        t_ext;
        chk("far stalls", i_far.stalls, 32'h0);
        end_sim;
    end
endmodule
`default_nettype wire
